// *** adcrt_top.sv ***
// adcrt_top: converter result, trigger and input-disable registers behind axi4-lite
// assumes trigger flags and core done pulse are on aclk; port pins are asynchronous
// Behaviour
// (R1) right adjust: bits 7:0 in low byte, 9:8 in high bits 1:0
// (R2) left adjust: bits 9:2 in high byte, 1:0 in low bits 7:6
// (R3) after low byte read, result bytes frozen until high byte read
// (R4) software reads low byte first unless left adjusted at 8 bits
// (R5) left-adjust change alters presentation immediately
// (R6) trigger source field acts only while auto triggering is enabled
// (R7) auto trigger starts conversion on rising edge of selected flag
// (R8) switching from clear to set source counts as rising edge
// (R9) selecting free running never triggers by itself
// (R10) source codes: free, comparator, ext0, t0 A, t0 ovf, t1 B, t1 ovf, t1 cap
// (R11) disable bit one turns off pin input buffer; first reg bits 7:3 ch4..0
// (R12) disabled channel reads zero in port input register
// (R13) second reg bits 3:0 ch8..5, third bits 2:0 ch11..9, rest zero
// (R14) software writes zero to control b bits 5:4
// (R15) software writes zero to control b bits 7:6; the write mask keeps bits 7:6 as written
// (R16) software should disable inputs of analog-only pins
// (R17) auto trigger active only while enable is one
// (R18) result completing while locked is discarded
`timescale 1ns/10ps
module adcrt_top
   import adcrt_pkg::*;
#(
   parameter int RES_W = 10
)(
   input  wire logic             aclk,            // system clock
   input  wire logic             aresetn,         // sync reset, active low
   input  wire logic [9:0]       s_axi_awaddr,    // write address
   input  wire logic             s_axi_awvalid,   // write address valid
   output logic                  s_axi_awready,   // write address ready
   input  wire logic [31:0]      s_axi_wdata,     // write data
   input  wire logic [3:0]       s_axi_wstrb,     // write strobes
   input  wire logic             s_axi_wvalid,    // write data valid
   output logic                  s_axi_wready,    // write data ready
   output logic      [1:0]       s_axi_bresp,     // write response
   output logic                  s_axi_bvalid,    // write response valid
   input  wire logic             s_axi_bready,    // write response ready
   input  wire logic [9:0]       s_axi_araddr,    // read address
   input  wire logic             s_axi_arvalid,   // read address valid
   output logic                  s_axi_arready,   // read address ready
   output logic      [31:0]      s_axi_rdata,     // read data
   output logic      [1:0]       s_axi_rresp,     // read response
   output logic                  s_axi_rvalid,    // read data valid
   input  wire logic             s_axi_rready,    // read data ready
   input  wire logic             conv_done,       // core conversion complete pulse
   input  wire logic [RES_W-1:0] conv_value,      // core result
   input  wire logic             conv_busy,       // core conversion in progress
   input  wire logic [7:1]       trig_flags,      // source flags 1..7
   input  wire logic [CHANNELS-1:0] pin_level,    // raw channel pin levels
   output logic                  conv_start,      // one-cycle start to core
   output logic                  converter_enable,// core enable
   output logic      [CHANNELS-1:0] buf_disable   // input buffer off per channel
);
   logic       aw_hold_q, w_hold_q;
   logic [7:0] aw_idx_q;
   logic [7:0] wdata_q;
   logic       wstrb_q;
   logic [7:0] ctlb_q;
   logic [7:0] dis0_q, dis1_q, dis2_q;
   logic       conv_en_q, auto_en_q, done_flag_q;
   logic [CHANNELS-1:0] pin_s1_q, pin_s2_q;
   logic [7:0] low_byte, high_byte;
   logic       trig_start;
   logic       wr_fire, rd_fire, rd_low, rd_high, wr_ok;
   logic [7:0] ar_idx;
   logic [7:0] rd_byte;
   logic       rd_ok;
   logic [CHANNELS-1:0] dis_all;
   logic [CHANNELS-1:0] pin_view;

   // write address and data are accepted independently, then joined
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         aw_idx_q      <= RESET_BYTE;
         wdata_q       <= RESET_BYTE;
         wstrb_q       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
         s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wstrb_q  <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
      wr_ok   = (aw_idx_q == IDX_RESULT_LOW) || (aw_idx_q == IDX_RESULT_HIGH)
                || (aw_idx_q == IDX_CONTROL_B) || (aw_idx_q == IDX_CONTROL_A)
                || (aw_idx_q == IDX_DISABLE_FIRST) || (aw_idx_q == IDX_DISABLE_SECOND)
                || (aw_idx_q == IDX_DISABLE_THIRD) || (aw_idx_q == IDX_PORT_INPUT);
   end

   // control b bits 5:4 and the unused upper bits of the second and third disable regs are forced to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctlb_q <= RESET_BYTE;
         dis0_q <= RESET_BYTE;
         dis1_q <= RESET_BYTE;
         dis2_q <= RESET_BYTE;
      end else if (wr_fire && wstrb_q) begin
         if (aw_idx_q == IDX_CONTROL_B) begin
            ctlb_q <= wdata_q & CTLB_WRITE_MASK;                   // R14 R15
         end else if (aw_idx_q == IDX_DISABLE_FIRST) begin
            dis0_q <= wdata_q & DIS_FIRST_MASK;                    // R11
         end else if (aw_idx_q == IDX_DISABLE_SECOND) begin
            dis1_q <= wdata_q & DIS_SECOND_MASK;                   // R13
         end else if (aw_idx_q == IDX_DISABLE_THIRD) begin
            dis2_q <= wdata_q & DIS_THIRD_MASK;                    // R13
         end
      end
   end

   // control a: enable, auto trigger, done flag (write one clears; set wins)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_en_q   <= 1'b0;
         auto_en_q   <= 1'b0;
         done_flag_q <= 1'b0;
      end else begin
         if (wr_fire && wstrb_q && aw_idx_q == IDX_CONTROL_A) begin
            conv_en_q <= wdata_q[CTLA_ENABLE];
            auto_en_q <= wdata_q[CTLA_AUTO_TRIGGER];               // R17
         end
         if (conv_done) begin
            done_flag_q <= 1'b1;
         end else if (wr_fire && wstrb_q && aw_idx_q == IDX_CONTROL_A
                      && wdata_q[CTLA_DONE_FLAG]) begin
            done_flag_q <= 1'b0;
         end
      end
   end

   // pins are asynchronous, so two stages before masking
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_level;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_comb begin
      dis_all  = {dis2_q[2:0], dis1_q[3:0], dis0_q[7:FIRST_CHAN_LSB]}; // R11 R13
      pin_view = pin_s2_q & ~dis_all;                              // R12
   end

   always_comb begin
      ar_idx  = s_axi_araddr[9:2];
      rd_fire = s_axi_arvalid && s_axi_arready;
      rd_ok   = 1'b1;
      rd_byte = RESET_BYTE;
      if (ar_idx == IDX_RESULT_LOW) begin
         rd_byte = low_byte;
      end else if (ar_idx == IDX_RESULT_HIGH) begin
         rd_byte = high_byte;
      end else if (ar_idx == IDX_CONTROL_B) begin
         rd_byte = ctlb_q;
      end else if (ar_idx == IDX_CONTROL_A) begin
         rd_byte = {conv_en_q, conv_busy, auto_en_q, done_flag_q, 4'h0};
      end else if (ar_idx == IDX_DISABLE_FIRST) begin
         rd_byte = dis0_q;
      end else if (ar_idx == IDX_DISABLE_SECOND) begin
         rd_byte = dis1_q;
      end else if (ar_idx == IDX_DISABLE_THIRD) begin
         rd_byte = dis2_q;
      end else if (ar_idx == IDX_PORT_INPUT) begin
         rd_byte = pin_view[7:0];                                  // R12
      end else begin
         rd_ok = 1'b0;
      end
      rd_low  = rd_fire && (ar_idx == IDX_RESULT_LOW);             // R3
      rd_high = rd_fire && (ar_idx == IDX_RESULT_HIGH);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   adcrt_result #(.RES_W(RES_W)) u_result (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .done      (conv_done),
      .value     (conv_value),
      .left_adj  (ctlb_q[CTLB_LEFT_ADJUST]),
      .rd_low    (rd_low),
      .rd_high   (rd_high),
      .low_byte  (low_byte),
      .high_byte (high_byte),
      .locked    ()
   );

   adcrt_trigger u_trigger (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .auto_en   (auto_en_q),
      .conv_en   (conv_en_q),
      .sel       (ctlb_q[2:0]),
      .src_flags ({trig_flags, done_flag_q}),
      .start     (trig_start)
   );

   // outputs registered; locked only matters inside the result holder
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_start       <= 1'b0;
         converter_enable <= 1'b0;
         buf_disable      <= '0;
      end else begin
         conv_start       <= trig_start;                           // R7
         converter_enable <= conv_en_q;
         buf_disable      <= dis_all;                              // R11
      end
   end
endmodule : adcrt_top

// *** adcrt_pkg.sv ***
// adcrt_pkg: register map, field positions and reset values of the converter register block
// assumes a 32-bit axi4-lite slave; printed offsets are indices, byte address = 4 * index
package adcrt_pkg;
   localparam logic [7:0]  IDX_RESULT_LOW     = 8'h00;
   localparam logic [7:0]  IDX_RESULT_HIGH    = 8'h01;
   localparam logic [7:0]  IDX_CONTROL_B      = 8'h02;
   localparam logic [7:0]  IDX_CONTROL_A      = 8'h03;
   localparam logic [7:0]  IDX_DISABLE_FIRST  = 8'h60;
   localparam logic [7:0]  IDX_DISABLE_SECOND = 8'h61;
   localparam logic [7:0]  IDX_DISABLE_THIRD  = 8'h62;
   localparam logic [7:0]  IDX_PORT_INPUT     = 8'h63;
   localparam int          CTLB_LEFT_ADJUST   = 3;
   localparam logic [7:0]  CTLB_WRITE_MASK    = 8'hcf;
   localparam logic [7:0]  DIS_FIRST_MASK     = 8'hff;
   localparam logic [7:0]  DIS_SECOND_MASK    = 8'h0f;
   localparam logic [7:0]  DIS_THIRD_MASK     = 8'h07;
   localparam int          CTLA_ENABLE        = 7;
   localparam int          CTLA_AUTO_TRIGGER  = 5;
   localparam int          CTLA_DONE_FLAG     = 4;
   localparam logic [7:0]  RESET_BYTE         = 8'h00;
   localparam logic [1:0]  RESP_OKAY          = 2'b00;
   localparam logic [1:0]  RESP_SLVERR        = 2'b10;
   localparam int          CHANNELS           = 12;
   localparam int          FIRST_CHAN_LSB     = 3;
   typedef enum logic [2:0] {
      ADCRT_SRC_FREE   = 3'h0,
      ADCRT_SRC_COMP   = 3'h1,
      ADCRT_SRC_EXT0   = 3'h2,
      ADCRT_SRC_T0CMPA = 3'h3,
      ADCRT_SRC_T0OVF  = 3'h4,
      ADCRT_SRC_T1CMPB = 3'h5,
      ADCRT_SRC_T1OVF  = 3'h6,
      ADCRT_SRC_T1CAP  = 3'h7
   } adcrt_src_t;
endpackage : adcrt_pkg

// *** adcrt_trigger.sv ***
// adcrt_trigger: selects the auto-trigger source flag and detects its rising edge
// assumes source flags are synchronous to aclk
`timescale 1ns/10ps
module adcrt_trigger
   import adcrt_pkg::*;
(
   input  wire logic       aclk,          // system clock
   input  wire logic       aresetn,       // sync reset, active low
   input  wire logic       auto_en,       // auto_trigger_enable
   input  wire logic       conv_en,       // converter_enable
   input  wire logic [2:0] sel,           // trigger_source_select
   input  wire logic [7:0] src_flags,     // flags; bit 0 is conversion_done_flag
   output logic            start          // one-cycle conversion start
);
   logic sel_flag;
   logic sel_flag_q;
   logic free_q;

   // free running repeats on the done flag; switching into it must not fire
   always_comb begin
      sel_flag = src_flags[sel];                                   // R10
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_flag_q <= 1'b0;
         free_q     <= 1'b0;
      end else begin
         sel_flag_q <= sel_flag;
         free_q     <= (adcrt_src_t'(sel) == ADCRT_SRC_FREE);
      end
   end

   // edge is on the selected signal, so a switch to a set flag other than free running also fires
   always_comb begin
      start = auto_en && conv_en && sel_flag && !sel_flag_q        // R6 R7 R8 R17
              && !((adcrt_src_t'(sel) == ADCRT_SRC_FREE) && !free_q); // R9
   end
endmodule : adcrt_trigger

// *** adcrt_result.sv ***
// adcrt_result: holds the conversion result, applies the read lock, formats both bytes
// assumes read strobes are one-cycle pulses from the bus slave
`timescale 1ns/10ps
module adcrt_result
   import adcrt_pkg::*;
#(
   parameter int RES_W = 10
)(
   input  wire logic             aclk,        // system clock
   input  wire logic             aresetn,     // sync reset, active low
   input  wire logic             done,        // conversion complete pulse
   input  wire logic [RES_W-1:0] value,       // result from core
   input  wire logic             left_adj,    // result_left_adjust
   input  wire logic             rd_low,      // low byte read pulse
   input  wire logic             rd_high,     // high byte read pulse
   output logic      [7:0]       low_byte,    // result_low_byte view
   output logic      [7:0]       high_byte,   // result_high_byte view
   output logic                  locked       // updates blocked
);
   logic [RES_W-1:0] res_q;
   logic             lock_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_q <= 1'b0;
      end else if (rd_low) begin
         lock_q <= 1'b1;                                           // R3
      end else if (rd_high) begin
         lock_q <= 1'b0;
      end
   end

   // a result arriving while locked is dropped, not queued
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_q <= '0;                                              // R1
      end else if (done && !lock_q && !rd_low) begin
         res_q <= value;                                           // R3 R18
      end
   end

   // presentation is combinational so the adjust bit acts at once
   always_comb begin
      if (left_adj) begin
         high_byte = res_q[9:2];                                   // R2 R5
         low_byte  = {res_q[1:0], 6'h00};                          // R2
      end else begin
         high_byte = {6'h00, res_q[9:8]};                          // R1 R5
         low_byte  = res_q[7:0];                                   // R1
      end
      locked = lock_q;
   end
endmodule : adcrt_result

// *** adcrt_core_model.sv ***
// adcrt_core_model: behavioural conversion core, answers conv_start after lat cycles
// assumes start pulses on aclk; trigger flags come from the bench
`timescale 1ns/10ps
module adcrt_core_model (
   input  wire logic       aclk,             // clock
   input  wire logic       aresetn,          // reset, active low
   input  wire logic       conv_start,       // start pulse
   input  wire logic       converter_enable, // core enable
   input  wire logic [7:0] lat,              // cycles to done, 1 up
   input  wire logic [9:0] val_in,           // next result
   output logic            conv_done,        // done pulse
   output logic      [9:0] conv_value,       // result with done
   output logic            conv_busy         // converting
);
   logic [7:0] cnt_q;
   // value bus shows junk outside done, so late sampling is caught
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q      <= 8'h00;
         conv_done  <= 1'h0;
         conv_value <= 10'h000;
      end else begin
         conv_done  <= 1'h0;
         conv_value <= ~val_in;
         if (!converter_enable) begin
            cnt_q <= 8'h00;
         end else if (conv_start && cnt_q == 8'h00) begin
            cnt_q <= lat;
         end else if (cnt_q == 8'h01) begin
            cnt_q      <= 8'h00;
            conv_done  <= 1'h1;
            conv_value <= val_in;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
   assign conv_busy = (cnt_q != 8'h00);
endmodule : adcrt_core_model

// *** adcrt_top_chk.sv ***
// adcrt_top_chk: bus handshake and register-side properties of adcrt_top
// assumes it is bound to adcrt_top and sees its ports only
`timescale 1ns/10ps
module adcrt_top_chk
   import adcrt_pkg::*;
(
   input wire logic                aclk,             // clock
   input wire logic                aresetn,          // reset
   input wire logic                s_axi_awready,    // aw ready
   input wire logic                s_axi_wvalid,     // w valid
   input wire logic                s_axi_wready,     // w ready
   input wire logic                s_axi_bvalid,     // b valid
   input wire logic                s_axi_arvalid,    // ar valid
   input wire logic                s_axi_arready,    // ar ready
   input wire logic [31:0]         s_axi_rdata,      // read data
   input wire logic                s_axi_rvalid,     // r valid
   input wire logic                conv_start,       // start
   input wire logic                converter_enable, // enable
   input wire logic [CHANNELS-1:0] buf_disable       // buffers off
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_hs;
      s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_hs;
      s_axi_arvalid && s_axi_arready;
   endsequence
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
      else $error("wready longer than one cycle");
   b_answer_a: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
      else $error("no write response");
   ar_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[0:1] s_axi_arready)
      else $error("read address not taken");
   r_answer_a: assert property (ar_hs |=> s_axi_rvalid)
      else $error("no read data");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   start_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   start_en_a: assert property (conv_start |-> converter_enable || $past(converter_enable))
      else $error("start while disabled");
   reset_idle_a: assert property ($rose(aresetn) |-> !conv_start && buf_disable == '0)
      else $error("outputs busy after reset");
   dis_change_a: assert property ($changed(buf_disable) |->
      $past(s_axi_bvalid) || !$past(aresetn))
      else $error("buffer disable moved without write");
   en_change_a: assert property ($changed(converter_enable) |->
      $past(s_axi_bvalid) || !$past(aresetn))
      else $error("enable moved without write");
endmodule : adcrt_top_chk

bind adcrt_top adcrt_top_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .conv_start, .converter_enable, .buf_disable);

// *** tb_adcrt_result_trigger_regs.sv ***
// tb_adcrt_result_trigger_regs: self-checking bench for adcrt_top
// assumes adcrt_core_model as the core; the bench drives trigger flags and pins
`timescale 1ns/10ps
module tb_adcrt_result_trigger_regs
   import adcrt_pkg::*;
;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, la;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic conv_done, conv_busy, conv_start, converter_enable;
   logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0, conv_value, val_in = '0, v;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, r, seed = 32'hbdb200da;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:1]  trig_flags = '0;
   logic [11:0] pin_level = '0, buf_disable;
   logic [7:0]  lat = 8'h02;
   logic [7:0]  idxs [0:6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h60, 8'h61, 8'h62};
   int          errors = 0, n_tests = 0, n_start = 0, s0;
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (conv_start === 1'h1) n_start <= n_start + 1;
   adcrt_top #(.RES_W(10)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .conv_done, .conv_value, .conv_busy, .trig_flags, .pin_level, .conv_start,
      .converter_enable, .buf_disable);
   adcrt_core_model u_core (.aclk, .aresetn, .conv_start, .converter_enable, .lat,
      .val_in, .conv_done, .conv_value, .conv_busy);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [7:0] exp_lo(input logic [9:0] x, input logic l);
      return l ? {x[1:0], 6'h00} : x[7:0];
   endfunction : exp_lo
   function automatic logic [7:0] exp_hi(input logic [9:0] x, input logic l);
      return l ? x[9:2] : {6'h00, x[9:8]};
   endfunction : exp_hi
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   // each task starts one edge late so no strobe is driven twice in a time step
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(32'(s_axi_bresp), 32'(er), "bresp");
   endtask : wr
   task automatic rdreg(input logic [7:0] idx);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rdreg
   task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string what);
      rdreg(idx);
      chk(32'(rsp), 32'(RESP_OKAY), what);
      chk(rd, {24'h0, e}, what);
   endtask : rc
   task automatic pulse(input int i);
      @(posedge aclk);
      trig_flags[i] <= 1'h1;
      repeat (3) @(posedge aclk);
      trig_flags[i] <= 1'h0;
      repeat (lat + 8) @(posedge aclk);
   endtask : pulse
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (idxs[i]) rc(idxs[i], 8'h00, "reset");
      wr(8'h00, 8'hff, RESP_OKAY);
      rc(8'h00, 8'h00, "ro");
      rc(8'h01, 8'h00, "ro");
      wr(8'h02, 8'hff, RESP_OKAY);
      rc(8'h02, 8'hcf, "ctlb");
      wr(8'h40, 8'h55, RESP_SLVERR);
      rdreg(8'h40);
      chk(32'(rsp), 32'(RESP_SLVERR), "unmapped");
      $display("test registers done");
      for (int k = 0; k < 6; k++) begin
         r = (k == 0) ? 32'hffffffff : rnd();
         pin_level <= r[31:20];
         wr(8'h60, r[7:0], RESP_OKAY);
         wr(8'h61, r[15:8], RESP_OKAY);
         wr(8'h62, r[23:16], RESP_OKAY);
         rc(8'h60, r[7:0], "dis1");
         rc(8'h61, r[15:8] & 8'h0f, "dis2");
         rc(8'h62, r[23:16] & 8'h07, "dis3");
         chk(32'(buf_disable), 32'({r[18:16], r[11:8], r[7:3]}), "buf");
         rc(8'h63, r[27:20] & ~{r[10:8], r[7:3]}, "pin");
      end
      s_axi_wstrb <= 4'h0;
      wr(8'h60, ~r[7:0], RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rc(8'h60, r[7:0], "strobe");
      $display("test input disable done");
      wr(8'h03, 8'ha0, RESP_OKAY);
      for (int s = 1; s < 8; s++) begin
         wr(8'h02, 8'(s), RESP_OKAY);
         s0 = n_start;
         pulse(s);
         pulse((s % 7) + 1);
         chk(32'(n_start - s0), 32'h1, "source");
      end
      rc(8'h03, 8'hb0, "ctla");
      chk(32'(converter_enable), 32'h1, "enable");
      wr(8'h03, 8'h80, RESP_OKAY);
      s0 = n_start;
      pulse(7);
      chk(32'(n_start - s0), 32'h0, "auto off");
      wr(8'h03, 8'ha0, RESP_OKAY);
      wr(8'h02, 8'h02, RESP_OKAY);
      trig_flags[3] <= 1'h1;
      repeat (4) @(posedge aclk);
      s0 = n_start;
      wr(8'h02, 8'h03, RESP_OKAY);
      trig_flags[3] <= 1'h0;
      wr(8'h02, 8'h00, RESP_OKAY);
      repeat (20) @(posedge aclk);
      chk(32'(n_start - s0), 32'h1, "switch");
      $display("test trigger done");
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         la = r[0];
         v = (k == 3) ? 10'h3ff : r[17:8];
         wr(8'h02, {4'h0, la, 3'h1}, RESP_OKAY);
         val_in <= v;
         pulse(1);
         rc(8'h00, exp_lo(v, la), "low");
         rc(8'h01, exp_hi(v, la), "high");
      end
      wr(8'h02, 8'h09, RESP_OKAY);
      rc(8'h00, exp_lo(v, 1'h1), "low");
      wr(8'h02, 8'h01, RESP_OKAY);
      rc(8'h01, exp_hi(v, 1'h0), "adjust");
      lat <= 8'h28;
      val_in <= ~v;
      s0 = n_start;
      @(posedge aclk);
      trig_flags[1] <= 1'h1;
      repeat (3) @(posedge aclk);
      trig_flags[1] <= 1'h0;
      rc(8'h00, exp_lo(v, 1'h0), "lock");
      repeat (60) @(posedge aclk);
      chk(32'(n_start - s0), 32'h1, "slow start");
      rc(8'h01, exp_hi(v, 1'h0), "held");
      rc(8'h00, exp_lo(v, 1'h0), "drop");
      rc(8'h01, exp_hi(v, 1'h0), "drop");
      $display("test result done");
      end_sim();
   end
endmodule : tb_adcrt_result_trigger_regs
